// ==== dv/uart_line_modem_status_test.sv ====
// Self-checking bench for the line and modem status block
`timescale 1ns/1ps
module uart_line_modem_status_test;
  import ulms_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [ULMS_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq, dtr_n, rts_n, out1_n, out2_n, rxv;
  logic [3:0] lines_n;
  ulms_rx_char_t rxc;
  int fail_count = 0;
  int checks = 0;
  initial forever #5 clk = ~clk;
  ulms_modem modem (.clk_i(clk), .lines_n_o(lines_n), .rx_valid_o(rxv), .rx_char_o(rxc));
  ulms_top u_dut (.CLOCK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_VALID_I(rxv), .RX_CHAR_I(rxc),
    .CD_N_I(lines_n[3]), .RI_N_I(lines_n[2]), .DSR_N_I(lines_n[1]),
    .CTS_N_I(lines_n[0]), .DTR_N_O(dtr_n), .RTS_N_O(rts_n),
    .USER_OUTPUT_ONE_N_O(out1_n), .USER_OUTPUT_TWO_N_O(out2_n), .IRQ_O(irq));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One APB transfer; answer taken at the rising edge that sees pready high
  task automatic apb(input logic wr, input logic [ULMS_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [ULMS_AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk
  task automatic t_scratch();
    apb(1'b1, ADDR_MODEM_CONTROL, 32'h3);
    apb(1'b1, ADDR_SCRATCH_STORE, 32'h1a5);
    rd_chk(ADDR_SCRATCH_STORE, 32'ha5);
    rd_chk(ADDR_MODEM_CONTROL, 32'h3);
    check({28'h0, dtr_n, rts_n, out1_n, out2_n}, 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask : t_scratch
  task automatic t_parity();
    apb(1'b1, ADDR_LINE_CONFIG, 32'h6);
    modem.send(8'h3c, 1'b1);
    rd_chk(ADDR_LINE_STATUS, 32'h5);
    rd_chk(ADDR_RX_DATA, 32'h3c);
    rd_chk(ADDR_LINE_STATUS, 32'h0);
  endtask : t_parity
  task automatic t_odd();
    apb(1'b1, ADDR_LINE_CONFIG, 32'h2);
    modem.send(8'h3c, 1'b1);
    modem.send(8'h55, 1'b0);
    rd_chk(ADDR_LINE_STATUS, 32'h3);
    rd_chk(ADDR_RX_DATA, 32'h3c);
    rd_chk(ADDR_LINE_STATUS, 32'h0);
  endtask : t_odd
  task automatic t_overrun();
    apb(1'b1, ADDR_LINE_CONFIG, 32'h7);
    for (int i = 0; i <= ULMS_DEPTH; i++) modem.send(8'(i + 8'h40), i == 0);
    rd_chk(ADDR_LINE_STATUS, 32'h7);
    rd_chk(ADDR_RX_DATA, 32'h40);
    rd_chk(ADDR_LINE_STATUS, 32'h1);
    for (int i = 1; i < ULMS_DEPTH; i++) rd_chk(ADDR_RX_DATA, 32'(i + 8'h40));
    rd_chk(ADDR_RX_DATA, 32'h0);
    rd_chk(ADDR_LINE_STATUS, 32'h0);
  endtask : t_overrun
  task automatic t_modem();
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    modem.set_lines(4'h0);
    repeat (5) @(negedge clk);
    check({31'h0, irq}, 32'h1);
    rd_chk(ADDR_MODEM_STATUS, 32'hfb);
    rd_chk(ADDR_MODEM_STATUS, 32'hf0);
    modem.set_lines(4'h4);
    repeat (5) @(negedge clk);
    rd_chk(ADDR_MODEM_STATUS, 32'hb4);
    apb(1'b1, ADDR_INT_STATUS, 32'hf);
    repeat (2) @(negedge clk);
    check({31'h0, irq}, 32'h0);
  endtask : t_modem
  task automatic t_loop();
    apb(1'b1, ADDR_MODEM_CONTROL, 32'h15);
    repeat (2) @(negedge clk);
    check({28'h0, dtr_n, rts_n, out1_n, out2_n}, 32'hf);
    apb(1'b0, ADDR_MODEM_STATUS, 32'h0);
    check(rd & 32'hf0, 32'h60);
    apb(1'b1, ADDR_MODEM_CONTROL, 32'h1a);
    apb(1'b0, ADDR_MODEM_STATUS, 32'h0);
    check(rd & 32'hf0, 32'h90);
  endtask : t_loop
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_scratch();
    t_parity();
    t_odd();
    t_overrun();
    t_modem();
    t_loop();
    summarize();
  end
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule : uart_line_modem_status_test

// ==== dv/ulms_modem.sv ====
// Modem and receiver stand-in driving the handshake and receive inputs
`timescale 1ns/1ps
module ulms_modem
  import ulms_pkg::*;
(
  input wire logic clk_i,
  output logic [3:0] lines_n_o,
  output logic rx_valid_o,
  output ulms_rx_char_t rx_char_o
);
  initial begin
    lines_n_o = 4'hf;
    rx_valid_o = 1'b0;
    rx_char_o = '0;
  end
  // Line order: carrier, ring, set ready, clear to send
  task automatic set_lines(input logic [3:0] v);
    @(posedge clk_i);
    lines_n_o <= v;
  endtask : set_lines
  // One character; parity is right for even mode unless bad is set
  task automatic send(input logic [7:0] d, input logic bad);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_char_o <= '{data: d, par: (^d) ^ bad};
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_char_o <= '{data: ~d, par: 1'b0};
  endtask : send
endmodule : ulms_modem

// ==== hw/ulms_pkg.sv ====
// Package for the line and modem status block: map, fields, reset values, types
package ulms_pkg;
  localparam int ULMS_AW = 8;
  localparam int ULMS_DEPTH = 16;
  localparam int ULMS_PW = 4;
  // Register byte offsets
  localparam logic [ULMS_AW-1:0] ADDR_RX_DATA = 8'h00;
  localparam logic [ULMS_AW-1:0] ADDR_LINE_STATUS = 8'h04;
  localparam logic [ULMS_AW-1:0] ADDR_MODEM_STATUS = 8'h08;
  localparam logic [ULMS_AW-1:0] ADDR_SCRATCH_STORE = 8'h0c;
  localparam logic [ULMS_AW-1:0] ADDR_MODEM_CONTROL = 8'h10;
  localparam logic [ULMS_AW-1:0] ADDR_LINE_CONFIG = 8'h14;
  localparam logic [ULMS_AW-1:0] ADDR_INT_STATUS = 8'h18;
  localparam logic [ULMS_AW-1:0] ADDR_INT_MASK = 8'h1c;
  // Line status fields
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  // Modem control fields
  localparam int MC_LOOP = 4;
  // Line config fields
  localparam int CFG_FIFO_EN = 0;
  localparam int CFG_PAR_EN = 1;
  localparam int CFG_PAR_EVEN = 2;
  // Interrupt status fields
  localparam int INT_MODEM = 0;
  localparam int INT_OVERRUN = 1;
  localparam int INT_PARITY = 2;
  localparam int INT_DATA = 3;
  // Reset values
  localparam logic [7:0] RST_MODEM_CONTROL = 8'h00;
  localparam logic [2:0] RST_LINE_CONFIG = 3'h0;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [3:0] RST_INT_MASK = 4'h0;
  localparam logic [3:0] RST_MODEM_OUT_N = 4'hf;
  typedef struct packed {
    logic [7:0] data;
    logic par;
  } ulms_rx_char_t;
  typedef struct packed {
    logic perr;
    logic [7:0] data;
  } ulms_entry_t;
endpackage : ulms_pkg

// ==== hw/ulms_top.sv ====
// Line and modem status logic of one channel, with APB register access
// Summary of operation
// - Parity error bit flags a bad-parity character; FIFO mode shows the head character.
// - Overrun bit sets when a character completes while the receive FIFO is full.
// - On overrun the shift register is overwritten and nothing is pushed.
// - Data ready is high while any character is held, low when none.
// - Normal mode: upper modem status bits are inverted active-low modem inputs.
// - Loop-back: bits 7,6,5,4 return modem control bits 3,2,0,1.
// - Carrier detect, data set ready, clear to send changes latch flags either way.
// - Reading modem status returns the flags, then clears only the flags it returned.
// - Ring change flag sets only when the ring input pin rises, or in loop-back when modem control bit 2 falls.
// - Any set change flag raises the modem status interrupt condition.
// - An 8-bit scratch register is written and read back by software.
`timescale 1ns/1ps
module ulms_top
  import ulms_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ULMS_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RX_VALID_I,
  input wire ulms_rx_char_t RX_CHAR_I,
  input wire logic CD_N_I,
  input wire logic RI_N_I,
  input wire logic DSR_N_I,
  input wire logic CTS_N_I,
  output logic DTR_N_O,
  output logic RTS_N_O,
  output logic USER_OUTPUT_ONE_N_O,
  output logic USER_OUTPUT_TWO_N_O,
  output logic IRQ_O
);

  // Registers
  logic [7:0] modem_control_r;
  logic [2:0] line_config_r;
  logic [7:0] scratch_store_r;
  logic [3:0] int_mask_r;
  logic [3:0] int_status_r;
  logic [3:0] int_status_nxt;
  logic [3:0] delta_r;
  logic [3:0] delta_nxt;
  logic [3:0] modem_prev_r;
  logic primed_r;
  logic overrun_r;
  logic overrun_nxt;
  ulms_rx_char_t rx_shift_r;
  ulms_entry_t fifo_mem [ULMS_DEPTH];
  logic [ULMS_PW-1:0] wr_ptr_r;
  logic [ULMS_PW-1:0] rd_ptr_r;
  logic [ULMS_PW:0] count_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic head_taken_r;
  logic [3:0] modem_out_n_r;
  logic irq_r;

  // Bus phases
  wire setup = PSEL_I && !PENABLE_I;
  wire done = PSEL_I && PENABLE_I && pready_r;
  wire wr_done = done && PWRITE_I;
  wire rd_done = done && !PWRITE_I;
  wire loop = modem_control_r[MC_LOOP];
  wire fifo_en = line_config_r[CFG_FIFO_EN];

  // Receive path
  wire [ULMS_PW:0] limit = fifo_en ? (ULMS_PW+1)'(ULMS_DEPTH) : (ULMS_PW+1)'(1);
  wire full = count_r >= limit;
  wire empty = count_r == '0;
  wire push = RX_VALID_I && !full;
  wire ovr_event = RX_VALID_I && full;
  wire pop = rd_done && PADDR_I == ADDR_RX_DATA && head_taken_r;
  wire par_expect = line_config_r[CFG_PAR_EVEN] ? ^RX_CHAR_I.data : ~^RX_CHAR_I.data;
  wire par_bad = line_config_r[CFG_PAR_EN] && (RX_CHAR_I.par != par_expect);
  ulms_entry_t head;
  assign head = fifo_mem[rd_ptr_r];
  wire head_perr = !empty && head.perr;
  wire [7:0] line_status = {5'h00, head_perr, overrun_r, !empty};

  // Modem status
  wire [3:0] modem_hi = loop ?
    {modem_control_r[3], modem_control_r[2], modem_control_r[0], modem_control_r[1]} :
    ~{CD_N_I, RI_N_I, DSR_N_I, CTS_N_I};
  wire [3:0] chg;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chg
      if (gi == 2) begin : g_ring
        assign chg[gi] = primed_r && modem_prev_r[gi] && !modem_hi[gi];
      end else begin : g_both
        assign chg[gi] = primed_r && (modem_prev_r[gi] ^ modem_hi[gi]);
      end
    end
  endgenerate
  wire [7:0] modem_status = {modem_hi, delta_r};
  wire msr_rd = rd_done && PADDR_I == ADDR_MODEM_STATUS;
  assign delta_nxt = (msr_rd ? delta_r & ~prdata_r[3:0] : delta_r) | chg;
  wire modem_int = |delta_r;

  // Sticky events
  wire lsr_rd = rd_done && PADDR_I == ADDR_LINE_STATUS;
  assign overrun_nxt = (lsr_rd && prdata_r[LS_OVERRUN] ? 1'b0 : overrun_r) | ovr_event;
  wire [3:0] events;
  assign events[INT_MODEM] = modem_int;
  assign events[INT_OVERRUN] = ovr_event;
  assign events[INT_PARITY] = push && par_bad;
  assign events[INT_DATA] = push && empty;
  wire ist_wr = wr_done && PADDR_I == ADDR_INT_STATUS;
  assign int_status_nxt = (int_status_r & ~(ist_wr ? PWDATA_I[3:0] : 4'h0)) | events;

  // Read decode
  logic [31:0] rdata;
  logic hit;
  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    if (PADDR_I == ADDR_RX_DATA) begin
      rdata = {24'h00_0000, empty ? 8'h00 : head.data};
    end else if (PADDR_I == ADDR_LINE_STATUS) begin
      rdata = {24'h00_0000, line_status};
    end else if (PADDR_I == ADDR_MODEM_STATUS) begin
      rdata = {24'h00_0000, modem_status};
    end else if (PADDR_I == ADDR_SCRATCH_STORE) begin
      rdata = {24'h00_0000, scratch_store_r};
    end else if (PADDR_I == ADDR_MODEM_CONTROL) begin
      rdata = {24'h00_0000, modem_control_r};
    end else if (PADDR_I == ADDR_LINE_CONFIG) begin
      rdata = {29'h0000_0000, line_config_r};
    end else if (PADDR_I == ADDR_INT_STATUS) begin
      rdata = {28'h000_0000, int_status_r};
    end else if (PADDR_I == ADDR_INT_MASK) begin
      rdata = {28'h000_0000, int_mask_r};
    end else begin
      hit = 1'b0;
    end
  end

  // Bus answer, zero wait states
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      head_taken_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !hit;
      if (setup && !PWRITE_I) begin
        prdata_r <= rdata;
        head_taken_r <= !empty;
      end
    end
  end

  // Software registers
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      modem_control_r <= RST_MODEM_CONTROL;
      line_config_r <= RST_LINE_CONFIG;
      scratch_store_r <= RST_SCRATCH;
      int_mask_r <= RST_INT_MASK;
    end else if (wr_done) begin
      if (PADDR_I == ADDR_SCRATCH_STORE) begin
        scratch_store_r <= PWDATA_I[7:0];
      end else if (PADDR_I == ADDR_MODEM_CONTROL) begin
        modem_control_r <= PWDATA_I[7:0];
      end else if (PADDR_I == ADDR_LINE_CONFIG) begin
        line_config_r <= PWDATA_I[2:0];
      end else if (PADDR_I == ADDR_INT_MASK) begin
        int_mask_r <= PWDATA_I[3:0];
      end
    end
  end

  // Status, interrupt and modem pins
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      delta_r <= 4'h0;
      modem_prev_r <= 4'h0;
      primed_r <= 1'b0;
      overrun_r <= 1'b0;
      int_status_r <= 4'h0;
      irq_r <= 1'b0;
      modem_out_n_r <= RST_MODEM_OUT_N;
    end else begin
      primed_r <= 1'b1;
      modem_prev_r <= modem_hi;
      delta_r <= delta_nxt;
      overrun_r <= overrun_nxt;
      int_status_r <= int_status_nxt;
      irq_r <= |(int_status_nxt & int_mask_r);
      modem_out_n_r <= loop ? RST_MODEM_OUT_N : ~modem_control_r[3:0];
    end
  end

  // Receive shift register and FIFO
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_shift_r <= '0;
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (RX_VALID_I) begin
        rx_shift_r <= RX_CHAR_I;
      end
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (ULMS_PW+1)'(push) - (ULMS_PW+1)'(pop);
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (push) begin
      fifo_mem[wr_ptr_r] <= '{perr: par_bad, data: RX_CHAR_I.data};
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign IRQ_O = irq_r;
  assign DTR_N_O = modem_out_n_r[0];
  assign RTS_N_O = modem_out_n_r[1];
  assign USER_OUTPUT_ONE_N_O = modem_out_n_r[2];
  assign USER_OUTPUT_TWO_N_O = modem_out_n_r[3];

  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  wire scr_wr = wr_done && PADDR_I == ADDR_SCRATCH_STORE;

  a_parity_head: assert property (push && empty && par_bad |=> line_status[LS_PARITY])
    else $error("parity flag missing for head character");
  a_overrun_set: assert property (ovr_event |=> overrun_r ##0 line_status[LS_OVERRUN])
    else $error("overrun flag not set");
  a_overrun_keep: assert property (ovr_event && !pop |=> $stable(count_r) && $stable(wr_ptr_r))
    else $error("overrun changed stored data");
  a_ready_level: assert property (push |=> line_status[LS_DATA_READY] ##0 count_r != '0)
    else $error("data ready low with data held");
  a_normal_read: assert property (setup && !PWRITE_I && !loop
    && PADDR_I == ADDR_MODEM_STATUS
    |=> PRDATA_O[7:4] == ~$past({CD_N_I, RI_N_I, DSR_N_I, CTS_N_I}))
    else $error("modem status not inverted inputs");
  a_loop_read: assert property (setup && !PWRITE_I && loop
    && PADDR_I == ADDR_MODEM_STATUS
    |=> PRDATA_O[7:4] == $past({modem_control_r[3:2], modem_control_r[0], modem_control_r[1]}))
    else $error("loop-back modem status wrong");
  a_cd_change: assert property (primed_r && !loop && $stable(loop) && $changed(CD_N_I)
    |=> delta_r[3])
    else $error("carrier change not latched");
  a_dsr_change: assert property (primed_r && !loop && $stable(loop) && $changed(DSR_N_I)
    |=> delta_r[1])
    else $error("set ready change not latched");
  a_cts_change: assert property (primed_r && !loop && $stable(loop) && $changed(CTS_N_I)
    |=> delta_r[0])
    else $error("clear to send change not latched");
  a_read_clear: assert property (msr_rd && chg == 4'h0
    |=> delta_r == ($past(delta_r) & ~$past(PRDATA_O[3:0])))
    else $error("change flags not cleared by read");
  a_ring_rise: assert property (primed_r && !loop && $fell(RI_N_I)
    && !delta_r[2] && !chg[2] |=> !delta_r[2])
    else $error("ring flag set on wrong edge");
  a_ring_set: assert property (primed_r && !loop && $stable(loop) && $rose(RI_N_I)
    |=> delta_r[2])
    else $error("ring release not latched");
  a_modem_int: assert property (modem_int |=> int_status_r[INT_MODEM])
    else $error("modem interrupt condition lost");
  a_modem_irq: assert property (int_status_r[INT_MODEM] && int_mask_r[INT_MODEM]
    && $stable(int_mask_r) |-> IRQ_O)
    else $error("masked-in modem interrupt not raised");
  a_scratch_rb: assert property (scr_wr |=> scratch_store_r == $past(PWDATA_I[7:0]))
    else $error("scratch value not stored");
  a_event_kept: assert property (msr_rd && chg != 4'h0
    |=> (delta_r & $past(chg)) == $past(chg))
    else $error("change lost at status read");
  a_scratch_iso: assert property (scr_wr |=> $stable(modem_control_r)
    && $stable(line_config_r) && $stable(int_mask_r))
    else $error("scratch write disturbed other state");
  a_shift_load: assert property (RX_VALID_I |=> rx_shift_r == $past(RX_CHAR_I))
    else $error("shift register not overwritten");
  a_lsr_keep: assert property (lsr_rd && overrun_r && !PRDATA_O[LS_OVERRUN]
    |=> overrun_r)
    else $error("unreported overrun cleared");
  a_rx_pop: assert property (pop |-> PRDATA_O[7:0] == head.data)
    else $error("popped character not the one returned");

  c_overrun: cover property (ovr_event ##1 lsr_rd);
  c_late_change: cover property (msr_rd && chg != 4'h0);
  c_ring: cover property (chg[2] ##[1:20] msr_rd);
  c_fifo_fill: cover property (fifo_en && count_r == (ULMS_PW+1)'(ULMS_DEPTH));
  c_irq: cover property ($rose(IRQ_O));
endmodule : ulms_top
